/* fault_cfg_pkg.sv */
package fault_cfg_pkg;

  // ******************************
  // Register map
  // ******************************
  localparam logic [7:0] CONTROL_ONE_ADDR = 8'hb0;
  localparam logic [7:0] LOW_BUS_FAULT_RESPONSE_ADDR = 8'hb1;
  localparam logic [7:0] FAULT_STATUS_ADDR = 8'hd2;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] LOW_BUS_FAULT_RESPONSE_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ******************************
  // Field positions
  // ******************************
  localparam int INDIVIDUAL_EN_BIT = 7;
  localparam int CLEAR_FAULTS_BIT = 6;
  localparam int POLARITY_INVERT_BIT = 5;
  localparam int TRACKING_SELECT_BIT = 4;
  localparam int CONTROL_STORED_MSB = 7;
  localparam int CONTROL_STORED_LSB = 4;
  localparam int OUT_OV_FIELD_LSB = 0;
  localparam int OUT_UV_FIELD_LSB = 2;
  localparam int FAULT_COUNT = 2;
  localparam int OUT_OV_STATUS_BIT = 0;
  localparam int OUT_UV_STATUS_BIT = 1;

  // ******************************
  // Response codes
  // ******************************
  localparam logic [1:0] RESP_FLAG_A = 2'h0;
  localparam logic [1:0] RESP_HICCUP = 2'h1;
  localparam logic [1:0] RESP_LATCH = 2'h2;
  localparam logic [1:0] RESP_FLAG_B = 2'h3;

  // ******************************
  // Timing
  // ******************************
  localparam longint CLOCK_HZ = 200000000;
  localparam longint HICCUP_DELAY_MS = 500;
  localparam longint HICCUP_CYCLES_DEFAULT = HICCUP_DELAY_MS * CLOCK_HZ / 1000;
  localparam int HICCUP_COUNT_W = 27;
  localparam int PHASE_COUNT = 6;

endpackage

/* fault_chan_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface fault_chan_if;
  logic cond;
  logic [1:0] code;
  logic latch_clear;
  logic stop;
  modport chan (input cond, input code, input latch_clear, output stop);
  modport ctrl (output cond, output code, output latch_clear, input stop);
endinterface
`default_nettype wire

/* fault_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module fault_channel
  import fault_cfg_pkg::*;
#(
  parameter longint HICCUP_CYCLES = HICCUP_CYCLES_DEFAULT,
  parameter int COUNT_W = HICCUP_COUNT_W
) (
  input wire logic i_clock,
  input wire logic i_rst,
  fault_chan_if.chan ch
);

  typedef enum logic [1:0] {RUNNING, HICCUP_HOLD, HICCUP_WAIT, LATCHED} chan_state_t;

  localparam logic [COUNT_W-1:0] RELOAD = COUNT_W'(HICCUP_CYCLES - 1);
  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  chan_state_t state, next_state;
  logic [COUNT_W-1:0] count, next_count;
  logic stop, next_stop;

  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      RUNNING: begin
        if (ch.cond && ch.code == RESP_HICCUP) begin
          next_state = HICCUP_HOLD;
        end else if (ch.cond && ch.code == RESP_LATCH) begin
          next_state = LATCHED;
        end
      end
      HICCUP_HOLD: begin
        if (!ch.cond) begin
          next_state = HICCUP_WAIT;
          next_count = RELOAD;
        end
      end
      HICCUP_WAIT: begin
        if (ch.cond) begin
          next_state = HICCUP_HOLD;
        end else if (count == '0) begin
          next_state = RUNNING;
        end else begin
          next_count = count - COUNT_ONE;
        end
      end
      LATCHED: begin
        if (ch.latch_clear) begin
          next_state = RUNNING;
        end
      end
    endcase
    next_stop = (next_state != RUNNING);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= RUNNING;
      count <= '0;
      stop <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      stop <= next_stop;
    end
  end

  assign ch.stop = stop;

  // ******************************
  // Checks
  // ******************************
  sequence s_latch_fault;
    state == RUNNING && ch.cond && ch.code == RESP_LATCH;
  endsequence

  sequence s_fault_gone;
    state == HICCUP_HOLD && !ch.cond;
  endsequence

  property p_latch_holds;
    @(posedge i_clock) disable iff (i_rst)
      s_latch_fault ##1 (!ch.latch_clear)[*3] |=> stop;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latch-off released early");

  property p_hiccup_reload;
    @(posedge i_clock) disable iff (i_rst)
      s_fault_gone |=> state == HICCUP_WAIT && count == RELOAD;
  endproperty
  a_hiccup_reload: assert property (p_hiccup_reload) else $error("hiccup delay not loaded");

  property p_hiccup_stop;
    @(posedge i_clock) disable iff (i_rst)
      state == RUNNING && ch.cond && ch.code == RESP_HICCUP |=> ##1 stop;
  endproperty
  a_hiccup_stop: assert property (p_hiccup_stop) else $error("hiccup did not stop");

  property p_flag_only;
    @(posedge i_clock) disable iff (i_rst)
      state == RUNNING && (ch.code == RESP_FLAG_A || ch.code == RESP_FLAG_B) |=> state == RUNNING;
  endproperty
  a_flag_only: assert property (p_flag_only) else $error("flag-only code stopped switching");

endmodule
`default_nettype wire

/* fault_response_config.sv */
`timescale 1ns/10ps
`default_nettype none
module fault_response_config
  import fault_cfg_pkg::*;
#(
  parameter int PHASES = PHASE_COUNT,
  parameter longint HICCUP_CYCLES = HICCUP_CYCLES_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_switch_enable,
  input wire logic [1:0] i_mode_response,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_cmd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_out_overvoltage,
  input wire logic i_out_undervoltage,
  input wire logic [PHASES-1:0] i_phase_active,
  input wire logic [PHASES-1:0] i_phase_high_side,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [PHASES-1:0] o_phase_output,
  output logic [PHASES-1:0] o_phase_output_oe,
  output logic o_tracking_input_select,
  output logic o_fault_flag_pin_out,
  output logic o_fault_flag_pin_oe,
  output logic o_switching_stopped
);

  // The whole block returns to defaults while the enable pin is low.
  logic rst_all;
  assign rst_all = i_rst | ~i_enable;

  // ******************************
  // Registers
  // ******************************
  logic [7:0] control_one, next_control_one;
  logic [7:0] low_bus_fault_response, next_low_bus_fault_response;
  logic [FAULT_COUNT-1:0] fault_status, next_fault_status;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic [FAULT_COUNT-1:0] fault_cond;
  logic [FAULT_COUNT-1:0] chan_stop;
  logic [1:0] code_ov, code_uv;

  assign fault_cond = {i_out_undervoltage, i_out_overvoltage};

  always_comb begin
    next_control_one = control_one;
    next_low_bus_fault_response = low_bus_fault_response;
    next_rdata = rdata;
    next_rvalid = i_reg_rd;
    if (i_reg_wr && i_reg_cmd == CONTROL_ONE_ADDR) begin
      next_control_one = '0;
      next_control_one[CONTROL_STORED_MSB:CONTROL_STORED_LSB] =
        i_reg_wdata[CONTROL_STORED_MSB:CONTROL_STORED_LSB];
    end
    if (i_reg_wr && i_reg_cmd == LOW_BUS_FAULT_RESPONSE_ADDR) begin
      next_low_bus_fault_response = i_reg_wdata;
    end
    if (i_reg_rd) begin
      unique case (i_reg_cmd)
        CONTROL_ONE_ADDR: next_rdata = control_one;
        LOW_BUS_FAULT_RESPONSE_ADDR: next_rdata = low_bus_fault_response;
        FAULT_STATUS_ADDR: next_rdata = {{(8 - FAULT_COUNT){1'b0}}, fault_status};
        default: next_rdata = READ_ZERO;
      endcase
    end
    // a live fault sets its bit over a status write clear, not over clear-faults
    // only a write, clear-faults or reset clears
    if (control_one[CLEAR_FAULTS_BIT]) begin
      next_fault_status = '0;
    end else if (i_reg_wr && i_reg_cmd == FAULT_STATUS_ADDR) begin
      next_fault_status = (fault_status & ~i_reg_wdata[FAULT_COUNT-1:0]) | fault_cond;
    end else begin
      next_fault_status = fault_status | fault_cond;
    end
  end

  always_ff @(posedge i_clock) begin
    if (rst_all) begin
      control_one <= CONTROL_ONE_RESET;
      low_bus_fault_response <= LOW_BUS_FAULT_RESPONSE_RESET;
      fault_status <= '0;
      rdata <= READ_ZERO;
      rvalid <= 1'b0;
    end else begin
      control_one <= next_control_one;
      low_bus_fault_response <= next_low_bus_fault_response;
      fault_status <= next_fault_status;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ******************************
  // Fault responses
  // ******************************
  // fields only count with the individual enable set
  assign code_ov = control_one[INDIVIDUAL_EN_BIT] ?
    low_bus_fault_response[OUT_OV_FIELD_LSB +: 2] : i_mode_response;
  assign code_uv = control_one[INDIVIDUAL_EN_BIT] ?
    low_bus_fault_response[OUT_UV_FIELD_LSB +: 2] : i_mode_response;

  fault_chan_if fch[FAULT_COUNT] ();

  genvar f;
  generate
    for (f = 0; f < FAULT_COUNT; f++) begin : g_fault
      assign fch[f].cond = fault_cond[f];
      assign fch[f].code = (f == OUT_OV_STATUS_BIT) ? code_ov : code_uv;
      // dropping the switching enable releases a latch
      assign fch[f].latch_clear = ~i_switch_enable;
      assign chan_stop[f] = fch[f].stop;
      fault_channel #(
        .HICCUP_CYCLES(HICCUP_CYCLES),
        .COUNT_W(HICCUP_COUNT_W)
      ) u_channel (
        .i_clock(i_clock),
        .i_rst(rst_all),
        .ch(fch[f])
      );
    end
  endgenerate

  // ******************************
  // Outputs
  // ******************************
  logic flag_oe, next_flag_oe;
  logic stopped, next_stopped;
  logic [PHASES-1:0] phase_out, next_phase_out;
  logic [PHASES-1:0] phase_oe, next_phase_oe;

  always_comb begin
    // any set status bit pulls the flag low
    next_flag_oe = |next_fault_status;
    next_stopped = |chan_stop;
  end

  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_phase
      // an undriven pin sits mid-level, both switches off
      assign next_phase_oe[p] = i_phase_active[p] & i_switch_enable & ~(|chan_stop);
      // polarity flips what a high level means
      assign next_phase_out[p] = next_phase_oe[p] &
        (i_phase_high_side[p] ^ control_one[POLARITY_INVERT_BIT]);
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (rst_all) begin
      flag_oe <= 1'b0;
      stopped <= 1'b0;
      phase_out <= '0;
      phase_oe <= '0;
    end else begin
      flag_oe <= next_flag_oe;
      stopped <= next_stopped;
      phase_out <= next_phase_out;
      phase_oe <= next_phase_oe;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;
  assign o_phase_output = phase_out;
  assign o_phase_output_oe = phase_oe;
  assign o_tracking_input_select = control_one[TRACKING_SELECT_BIT];
  assign o_fault_flag_pin_out = 1'b0;
  assign o_fault_flag_pin_oe = flag_oe;
  assign o_switching_stopped = stopped;

  // ******************************
  // Checks
  // ******************************
  property p_ov_status;
    @(posedge i_clock) disable iff (rst_all)
      i_out_overvoltage && !control_one[CLEAR_FAULTS_BIT] |=> fault_status[OUT_OV_STATUS_BIT];
  endproperty
  a_ov_status: assert property (p_ov_status) else $error("overvoltage status not set");

  property p_uv_status;
    @(posedge i_clock) disable iff (rst_all)
      i_out_undervoltage && !control_one[CLEAR_FAULTS_BIT] |=> fault_status[OUT_UV_STATUS_BIT];
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("undervoltage status not set");

  property p_flag_follows;
    @(posedge i_clock) disable iff (rst_all)
      fault_status != '0 |-> o_fault_flag_pin_oe && !o_fault_flag_pin_out;
  endproperty
  a_flag_follows: assert property (p_flag_follows) else $error("fault flag not pulled low");

  property p_status_sticky;
    @(posedge i_clock) disable iff (rst_all)
      fault_status[0] && !i_reg_wr && !control_one[CLEAR_FAULTS_BIT] |=> fault_status[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status cleared itself");

  property p_polarity;
    @(posedge i_clock) disable iff (rst_all)
      next_phase_oe[0] |=> o_phase_output[0] ==
        ($past(i_phase_high_side[0]) ^ $past(control_one[POLARITY_INVERT_BIT]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("phase polarity wrong");

  property p_stop_quiet;
    @(posedge i_clock) disable iff (rst_all)
      |chan_stop |=> o_phase_output_oe == '0 && o_phase_output == '0;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("phases switch while stopped");

  property p_mode_default;
    @(posedge i_clock) disable iff (rst_all)
      !control_one[INDIVIDUAL_EN_BIT] && i_out_overvoltage && !chan_stop[OUT_OV_STATUS_BIT] &&
        (i_mode_response == RESP_FLAG_A || i_mode_response == RESP_FLAG_B) |=>
        !chan_stop[OUT_OV_STATUS_BIT];
  endproperty
  a_mode_default: assert property (p_mode_default) else $error("field used while disabled");

  property p_tracking;
    @(posedge i_clock) disable iff (rst_all)
      i_reg_wr && i_reg_cmd == CONTROL_ONE_ADDR |=>
        o_tracking_input_select == $past(i_reg_wdata[TRACKING_SELECT_BIT]);
  endproperty
  a_tracking: assert property (p_tracking) else $error("tracking select not written");

endmodule
`default_nettype wire

/* fet_driver_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Gate driver front end
// ********************************
// The driver is strapped to the same polarity as the controller, so the
// bench hands it the polarity that it last wrote.
module fet_driver_model #(
  parameter int PHASES = 6
) (
  input wire logic [PHASES-1:0] i_phase_output,
  input wire logic [PHASES-1:0] i_phase_output_oe,
  input wire logic i_invert,
  output logic [PHASES-1:0] o_high_on,
  output logic [PHASES-1:0] o_low_on
);
  always_comb begin
    o_high_on = i_phase_output_oe & (i_phase_output ^ {PHASES{i_invert}});
    o_low_on = i_phase_output_oe & ~(i_phase_output ^ {PHASES{i_invert}});
  end
endmodule
`default_nettype wire

/* fault_response_config_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module fault_response_config_bench;
  import fault_cfg_pkg::*;
  localparam longint HC = 8;
  logic i_clock, i_rst, i_enable, i_switch_enable, i_reg_wr, i_reg_rd, inv;
  logic i_out_overvoltage, i_out_undervoltage, o_reg_rvalid, o_tracking_input_select;
  logic o_fault_flag_pin_out, o_fault_flag_pin_oe, o_switching_stopped;
  logic [1:0] i_mode_response;
  logic [7:0] i_reg_cmd, i_reg_wdata, o_reg_rdata;
  logic [PHASE_COUNT-1:0] i_phase_active, i_phase_high_side, o_phase_output, o_phase_output_oe;
  logic [PHASE_COUNT-1:0] high_on, low_on;
  // The flag line has a pull-up, so a released pin reads high.
  wire fault_line = o_fault_flag_pin_oe ? o_fault_flag_pin_out : 1'b1;
  int err_count = 0;
  int comparisons = 0;

  fault_response_config #(.HICCUP_CYCLES(HC)) uut (.i_clock(i_clock), .i_rst(i_rst),
    .i_enable(i_enable), .i_switch_enable(i_switch_enable), .i_mode_response(i_mode_response),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_cmd(i_reg_cmd), .i_reg_wdata(i_reg_wdata),
    .i_out_overvoltage(i_out_overvoltage), .i_out_undervoltage(i_out_undervoltage),
    .i_phase_active(i_phase_active), .i_phase_high_side(i_phase_high_side),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_phase_output(o_phase_output),
    .o_phase_output_oe(o_phase_output_oe), .o_tracking_input_select(o_tracking_input_select),
    .o_fault_flag_pin_out(o_fault_flag_pin_out), .o_fault_flag_pin_oe(o_fault_flag_pin_oe),
    .o_switching_stopped(o_switching_stopped));
  fet_driver_model #(.PHASES(PHASE_COUNT)) drv (.i_phase_output(o_phase_output),
    .i_phase_output_oe(o_phase_output_oe), .i_invert(inv), .o_high_on(high_on),
    .o_low_on(low_on));

  // ********************************
  // Bench tasks
  // ********************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    i_reg_cmd = cmd;
    i_reg_wdata = data;
    i_reg_wr = 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] cmd, input logic [7:0] exp, input string msg);
    i_reg_cmd = cmd;
    i_reg_rd = 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    for (int k = 0; k < 3 && o_reg_rvalid !== 1'b1; k++) tick(1);
    check(o_reg_rvalid === 1'b1 ? o_reg_rdata : 8'hxx, exp, msg);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
    return {w[7:4], 4'h0};
  endfunction
  function automatic logic stop_exp(input logic [1:0] c);
    return c == RESP_HICCUP || c == RESP_LATCH;
  endfunction

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    logic [7:0] v;
    logic [1:0] code;
    logic f, ind, s;
    {i_rst, i_enable, i_switch_enable, inv} = 4'hf;
    {i_reg_wr, i_reg_rd, i_out_overvoltage, i_out_undervoltage} = 4'h0;
    {i_mode_response, i_reg_cmd, i_reg_wdata} = 18'h0;
    {i_phase_active, i_phase_high_side} = '0;
    void'($urandom(32'h3470));
    tick(10);
    i_rst = 1'b0;
    inv = 1'b0;
    rdc(CONTROL_ONE_ADDR, CONTROL_ONE_RESET, "control reset");
    rdc(LOW_BUS_FAULT_RESPONSE_ADDR, LOW_BUS_FAULT_RESPONSE_RESET, "response reset");
    rdc(FAULT_STATUS_ADDR, 8'h00, "status reset");
    rdc(8'h5a, READ_ZERO, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'hbf;
      inv = v[POLARITY_INVERT_BIT];
      wr(CONTROL_ONE_ADDR, v);
      rdc(CONTROL_ONE_ADDR, ctrl_exp(v), "control readback");
      check(8'(o_tracking_input_select), 8'(v[TRACKING_SELECT_BIT]), "tracking");
      i_phase_active = PHASE_COUNT'($urandom);
      i_phase_high_side = PHASE_COUNT'($urandom);
      tick(2);
      check(8'(high_on), 8'(i_phase_active & i_phase_high_side), "high side");
      check(8'(low_on), 8'(i_phase_active & ~i_phase_high_side), "low side");
    end
    inv = 1'b0;
    i_phase_active = '1;
    for (int n = 0; n < 16; n++) begin
      code = n[1:0];
      f = n[2];
      ind = n[3];
      s = stop_exp(code);
      wr(CONTROL_ONE_ADDR, {ind, 7'h00});
      // The unused code goes to the ignored source so that a mixed-up select shows.
      v = ind ? {6'h0, code} : {6'h0, code ^ 2'h1};
      v = f ? v << 2 : v;
      wr(LOW_BUS_FAULT_RESPONSE_ADDR, v | (8'($urandom) & (f ? 8'hf3 : 8'hfc)));
      i_mode_response = ind ? code ^ 2'h1 : code;
      i_out_overvoltage = ~f;
      i_out_undervoltage = f;
      tick(4);
      check(8'(o_switching_stopped), 8'(s), "stop on fault");
      check(8'(o_phase_output_oe), s ? 8'h00 : 8'(i_phase_active), "phases off");
      check(8'(fault_line), 8'h00, "flag low");
      rdc(FAULT_STATUS_ADDR, f ? 8'h02 : 8'h01, "status set");
      i_out_overvoltage = 1'b0;
      i_out_undervoltage = 1'b0;
      tick(int'(HC) + 4);
      check(8'(o_switching_stopped), 8'(code == RESP_LATCH), "after clear");
      i_switch_enable = 1'b0;
      tick(1);
      i_switch_enable = 1'b1;
      tick(3);
      check(8'(o_switching_stopped), 8'h00, "restart");
      rdc(FAULT_STATUS_ADDR, f ? 8'h02 : 8'h01, "status kept");
      wr(FAULT_STATUS_ADDR, f ? 8'h02 : 8'h01);
      tick(1);
      check(8'(fault_line), 8'h01, "flag released");
    end
    // A fault that returns before the delay expires must restart the wait.
    wr(CONTROL_ONE_ADDR, 8'h80);
    wr(LOW_BUS_FAULT_RESPONSE_ADDR, {6'h0, RESP_HICCUP});
    i_out_overvoltage = 1'b1;
    tick(3);
    i_out_overvoltage = 1'b0;
    tick(int'(HC) / 2);
    i_out_overvoltage = 1'b1;
    tick(1);
    i_out_overvoltage = 1'b0;
    tick(int'(HC) - 2);
    check(8'(o_switching_stopped), 8'h01, "reloaded wait");
    tick(8);
    check(8'(o_switching_stopped), 8'h00, "hiccup done");
    i_mode_response = RESP_FLAG_A;
    wr(CONTROL_ONE_ADDR, 8'h40);
    i_out_overvoltage = 1'b1;
    tick(3);
    rdc(FAULT_STATUS_ADDR, 8'h00, "clear held");
    wr(CONTROL_ONE_ADDR, 8'h00);
    tick(2);
    rdc(FAULT_STATUS_ADDR, 8'h01, "fault returns");
    i_out_overvoltage = 1'b0;
    wr(LOW_BUS_FAULT_RESPONSE_ADDR, 8'ha5);
    rdc(LOW_BUS_FAULT_RESPONSE_ADDR, 8'ha5, "response readback");
    i_enable = 1'b0;
    tick(1);
    i_enable = 1'b1;
    rdc(LOW_BUS_FAULT_RESPONSE_ADDR, 8'h00, "enable reset");
    rdc(FAULT_STATUS_ADDR, 8'h00, "status reset");
    stop_test();
  end
endmodule
`default_nettype wire
